// ==== verilog/serial_regs_pkg.sv ====
// Constants, register indices and carrier types for the serial channel register bank.
// Assumes an APB slave with 32-bit data; only the low byte of each word is live.
package serial_regs_pkg;

    localparam int NUM_CHAN = 2;
    localparam int IDX_W = 4;
    localparam int NUM_REGS = 16;
    localparam int ADDR_W = 8;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Address map: byte address = channel * 0x40 + register index * 4
    localparam int CHAN_BIT = 6;
    localparam int IDX_LSB = 2;
    localparam logic [ADDR_W-1:0] CHAN_SPACE_END = 8'h80;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'h80;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h84;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Register indices, shared by the write and the read space of a channel
    localparam logic [IDX_W-1:0] IDX_PRIMARY = 4'h0;
    localparam logic [IDX_W-1:0] IDX_SPECIAL = 4'h1;
    localparam logic [IDX_W-1:0] IDX_VECTOR = 4'h2;
    localparam logic [IDX_W-1:0] IDX_PENDING = 4'h3;
    localparam logic [IDX_W-1:0] IDX_CMD_FOUR = 4'h4;
    localparam logic [IDX_W-1:0] IDX_CMD_FIVE = 4'h5;
    localparam logic [IDX_W-1:0] IDX_FRAME_LOW = 4'h6;
    localparam logic [IDX_W-1:0] IDX_FRAME_HIGH = 4'h7;
    localparam logic [IDX_W-1:0] IDX_RX_DATA = 4'h8;
    localparam logic [IDX_W-1:0] IDX_CMD_THREE_RB = 4'h9;
    localparam logic [IDX_W-1:0] IDX_MISC_STATUS = 4'ha;
    localparam logic [IDX_W-1:0] IDX_ENABLES_ALIAS = 4'hb;
    localparam logic [IDX_W-1:0] IDX_TC_LOW = 4'hc;
    localparam logic [IDX_W-1:0] IDX_TC_HIGH = 4'hd;
    localparam logic [IDX_W-1:0] IDX_CMD_TEN_RB = 4'he;
    localparam logic [IDX_W-1:0] IDX_ENABLES = 4'hf;
    localparam logic [IDX_W-1:0] IDX_CMD_THREE = 4'h3;
    localparam logic [IDX_W-1:0] IDX_CMD_TEN = 4'ha;
    localparam logic [IDX_W-1:0] IDX_FEATURE = 4'h7;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam logic [7:0] ENABLES_RESET = 8'hf8;
    localparam logic [7:0] EXT_ENABLE_MASK = 8'hfa;
    localparam int EN_FEATURE_SEL_BIT = 0;
    localparam int EN_ZERO_COUNT_BIT = 1;
    localparam int EN_FIFO_BIT = 2;
    localparam int FEATURE_READBACK_BIT = 6;
    localparam int VEC_CODE_LSB = 1;
    localparam int IP_W = 6;
    localparam int IP_A_RX = 5;
    localparam int IP_A_TX = 4;
    localparam int IP_A_EXT = 3;
    localparam int IP_B_RX = 2;
    localparam int IP_B_TX = 1;
    localparam int IP_B_EXT = 0;
    localparam logic [2:0] VEC_B_TX = 3'h0;
    localparam logic [2:0] VEC_B_EXT = 3'h1;
    localparam logic [2:0] VEC_B_RX = 3'h2;
    localparam logic [2:0] VEC_NONE = 3'h3;
    localparam logic [2:0] VEC_A_TX = 3'h4;
    localparam logic [2:0] VEC_A_EXT = 3'h5;
    localparam logic [2:0] VEC_A_RX = 3'h6;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic break_abort;
        logic tx_underrun;
        logic cts;
        logic sync_hunt;
        logic dcd;
        logic tx_empty;
        logic zero_count;
        logic rx_avail;
    } primary_status_t;

    typedef struct packed {
        primary_status_t primary;
        logic eof;
        logic crc_err;
        logic overrun;
        logic parity_err;
        logic [2:0] residue;
        logic all_sent;
        logic [7:0] rx_data;
        logic [7:0] misc_status;
        logic [7:0] frame_count_low;
        logic [7:0] frame_count_high;
    } chan_in_t;

    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] wr;
        logic [7:0] feature;
    } chan_ctrl_t;

endpackage : serial_regs_pkg

// ==== verilog/channel_write_bank.sv ====
// Write-register storage of one channel, indexed by register number.
// Assumes wr_en is a one-cycle strobe from the bus slave on the same clock.
`timescale 1ns/1ps
module channel_write_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [serial_regs_pkg::IDX_W-1:0] wr_idx,
    input wire logic [7:0] wr_data,
    output serial_regs_pkg::chan_ctrl_t ctrl
);
    import serial_regs_pkg::*;

    logic [NUM_REGS-1:0][7:0] wr_reg;
    logic [7:0] feature_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Index 7 is steered to the extended feature register while enable bit 0 is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feature_reg <= 8'h00;
        end else if (wr_en && wr_idx == IDX_FEATURE && wr_reg[IDX_ENABLES][EN_FEATURE_SEL_BIT]) begin
            feature_reg <= wr_data;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_store
            localparam logic [IDX_W-1:0] MY_IDX = IDX_W'(g);
            localparam logic [7:0] MY_RESET = (MY_IDX == IDX_ENABLES) ? ENABLES_RESET : 8'h00;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    wr_reg[g] <= MY_RESET;
                end else if (wr_en && wr_idx == MY_IDX &&
                             !(MY_IDX == IDX_FEATURE && wr_reg[IDX_ENABLES][EN_FEATURE_SEL_BIT])) begin
                    wr_reg[g] <= wr_data;
                end
            end
        end
    endgenerate

    // One driver for the whole carrier
    assign ctrl = {wr_reg, feature_reg};

endmodule : channel_write_bank

// ==== verilog/serial_channel_status_regs.sv ====
// Two-channel serial controller register bank behind an APB slave.
// Assumes status inputs come from datapath logic on pclk; control outputs feed that datapath.
// Summary of operation
// - The interrupt-source enable register holds break, underrun, CTS, carrier and zero-count enables, zero count in bit 1.
// - Read registers six and seven show the frame-status FIFO only while enable bit 2 is 1.
// - With feature bit 6 set, write registers three, four, five and ten read back at nine, four, five and fourteen.
// - Each channel offers its read registers plus the receive data buffer at read index eight.
// - Status is read at read registers zero, one and ten; read register fifteen returns the interrupt-source enables.
// - Read registers twelve and thirteen return the low and high baud time constant.
// - The vector register reads unmodified through channel A and status-modified through channel B.
// - The pending register through channel A shows A in bits 5..3 and B in bits 2..0, upper bits and channel B reads 0.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module serial_channel_status_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [serial_regs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input serial_regs_pkg::chan_in_t [serial_regs_pkg::NUM_CHAN-1:0] chan_status,
    output serial_regs_pkg::chan_ctrl_t [serial_regs_pkg::NUM_CHAN-1:0] chan_ctrl
);
    import serial_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Read decode, shared by both channels
    function automatic logic [7:0] special_byte(input chan_in_t st);
        special_byte = {st.eof, st.crc_err, st.overrun, st.parity_err,
                        st.residue[0], st.residue[1], st.residue[2], st.all_sent};
    endfunction : special_byte

    function automatic logic [7:0] read_reg(
        input logic [IDX_W-1:0] idx,
        input chan_in_t st,
        input chan_ctrl_t ct,
        input logic [7:0] vec,
        input logic [7:0] pend
    );
        logic readback;
        logic fifo_on;
        readback = ct.feature[FEATURE_READBACK_BIT];
        fifo_on = ct.wr[IDX_ENABLES][EN_FIFO_BIT];
        case (idx)
            IDX_PRIMARY: read_reg = st.primary;
            IDX_SPECIAL: read_reg = special_byte(st);
            IDX_VECTOR: read_reg = vec;
            IDX_PENDING: read_reg = pend;
            IDX_CMD_FOUR: read_reg = readback ? ct.wr[IDX_CMD_FOUR] : st.primary;
            IDX_CMD_FIVE: read_reg = readback ? ct.wr[IDX_CMD_FIVE] : special_byte(st);
            IDX_FRAME_LOW: read_reg = fifo_on ? st.frame_count_low : vec;
            IDX_FRAME_HIGH: read_reg = fifo_on ? st.frame_count_high : pend;
            IDX_RX_DATA: read_reg = st.rx_data;
            IDX_CMD_THREE_RB: read_reg = readback ? ct.wr[IDX_CMD_THREE] : ct.wr[IDX_TC_HIGH];
            IDX_MISC_STATUS: read_reg = st.misc_status;
            IDX_ENABLES_ALIAS: read_reg = ct.wr[IDX_ENABLES];
            IDX_TC_LOW: read_reg = ct.wr[IDX_TC_LOW];
            IDX_TC_HIGH: read_reg = ct.wr[IDX_TC_HIGH];
            IDX_CMD_TEN_RB: read_reg = readback ? ct.wr[IDX_CMD_TEN] : st.misc_status;
            IDX_ENABLES: read_reg = ct.wr[IDX_ENABLES];
            default: read_reg = 8'h00;
        endcase
    endfunction : read_reg

    ////////////////////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, so every access completes at the second access edge
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic access;
    logic complete;
    logic chan_space;
    logic addr_ok;
    logic chan_sel;
    logic [IDX_W-1:0] reg_idx;

    assign access = psel && penable;
    assign complete = access && pready_reg;
    assign chan_space = paddr < CHAN_SPACE_END;
    assign addr_ok = (paddr[IDX_LSB-1:0] == 2'b00) &&
                     (chan_space || paddr == IRQ_STATUS_ADDR || paddr == IRQ_MASK_ADDR);
    assign chan_sel = paddr[CHAN_BIT];
    assign reg_idx = paddr[IDX_LSB +: IDX_W];

    assign pready_next = access && !pready_reg;
    assign pslverr_next = access && !pready_reg && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Channel write banks and edge detectors for status events
    logic [NUM_CHAN-1:0] bank_wr_en;
    primary_status_t [NUM_CHAN-1:0] primary_prev_reg;
    logic [NUM_CHAN-1:0] ext_event;
    logic [NUM_CHAN-1:0] rx_event;
    logic [NUM_CHAN-1:0] tx_event;

    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++) begin : g_chan
            assign bank_wr_en[c] = complete && pwrite && chan_space && addr_ok && (chan_sel == 1'(c));

            channel_write_bank u_bank (
                .pclk(pclk),
                .presetn(presetn),
                .wr_en(bank_wr_en[c]),
                .wr_idx(reg_idx),
                .wr_data(pwdata[7:0]),
                .ctrl(chan_ctrl[c])
            );

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    primary_prev_reg[c] <= '0;
                end else begin
                    primary_prev_reg[c] <= chan_status[c].primary;
                end
            end

            // Only sources enabled in the interrupt-source enables raise external/status
            assign ext_event[c] = |(chan_status[c].primary & ~primary_prev_reg[c] &
                                    chan_ctrl[c].wr[IDX_ENABLES] & EXT_ENABLE_MASK);
            assign rx_event[c] = chan_status[c].primary.rx_avail && !primary_prev_reg[c].rx_avail;
            assign tx_event[c] = chan_status[c].primary.tx_empty && !primary_prev_reg[c].tx_empty;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Sticky pending bits, mask and interrupt line
    logic [IP_W-1:0] pending_reg;
    logic [IP_W-1:0] pending_set;
    logic [IP_W-1:0] mask_reg;
    logic irq_reg;
    logic status_read;

    assign pending_set = {rx_event[0], tx_event[0], ext_event[0], rx_event[1], tx_event[1], ext_event[1]};
    assign status_read = complete && !pwrite && paddr == IRQ_STATUS_ADDR;

    // Set wins over the clear-on-read in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_reg <= '0;
        end else begin
            pending_reg <= (status_read ? '0 : pending_reg) | pending_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= '0;
        end else if (complete && pwrite && paddr == IRQ_MASK_ADDR) begin
            mask_reg <= pwdata[IP_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(pending_reg & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Vector: channel B replaces bits 3..1 with the highest-priority pending source
    logic [7:0] vector_base;
    logic [2:0] vec_code;
    logic [7:0] vector_mod;
    logic [7:0] pend_byte;

    assign vector_base = chan_ctrl[0].wr[IDX_VECTOR];

    always_comb begin
        if (pending_reg[IP_A_RX]) begin
            vec_code = VEC_A_RX;
        end else if (pending_reg[IP_A_TX]) begin
            vec_code = VEC_A_TX;
        end else if (pending_reg[IP_A_EXT]) begin
            vec_code = VEC_A_EXT;
        end else if (pending_reg[IP_B_RX]) begin
            vec_code = VEC_B_RX;
        end else if (pending_reg[IP_B_TX]) begin
            vec_code = VEC_B_TX;
        end else if (pending_reg[IP_B_EXT]) begin
            vec_code = VEC_B_EXT;
        end else begin
            vec_code = VEC_NONE;
        end
    end

    always_comb begin
        vector_mod = vector_base;
        vector_mod[VEC_CODE_LSB +: 3] = vec_code;
    end

    assign pend_byte = {2'b00, pending_reg};

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Read data, captured as pready rises so it is stable in the completing cycle
    always_comb begin
        prdata_next = prdata_reg;
        if (access && !pready_reg) begin
            prdata_next = 32'h0000_0000;
            if (!pwrite && addr_ok) begin
                if (paddr == IRQ_STATUS_ADDR) begin
                    prdata_next[IP_W-1:0] = pending_reg;
                end else if (paddr == IRQ_MASK_ADDR) begin
                    prdata_next[IP_W-1:0] = mask_reg;
                end else if (chan_sel) begin
                    prdata_next[7:0] = read_reg(reg_idx, chan_status[1], chan_ctrl[1], vector_mod, 8'h00);
                end else begin
                    prdata_next[7:0] = read_reg(reg_idx, chan_status[0], chan_ctrl[0], vector_base, pend_byte);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else begin
            prdata_reg <= prdata_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;

endmodule : serial_channel_status_regs

// ==== dv/serial_channel_status_regs_properties.sv ====
// Port-level checks for the serial channel register bank.
// Assumes the bench holds channel status steady across each read.
`timescale 1ns/1ps
module serial_channel_status_regs_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [serial_regs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input serial_regs_pkg::chan_in_t [serial_regs_pkg::NUM_CHAN-1:0] chan_status,
    input serial_regs_pkg::chan_ctrl_t [serial_regs_pkg::NUM_CHAN-1:0] chan_ctrl
);
    import serial_regs_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready;
    wire rd_ok = acc && !pwrite;
    ////////////////////////////////////////
    one_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("answer not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (acc && (paddr[1:0] != 2'b00 || paddr >= 8'h88)
        |-> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    primary_read_a: assert property (rd_ok && paddr == 8'h00
        |-> prdata == {24'h00_0000, $past(chan_status[0].primary)})
        else $error("primary status read wrong");
    rx_data_read_a: assert property (rd_ok && paddr == 8'h60
        |-> prdata[7:0] == $past(chan_status[1].rx_data))
        else $error("receive buffer read wrong");
    pend_b_zero_a: assert property (rd_ok && paddr == 8'h4c |-> prdata == 32'h0000_0000)
        else $error("channel B pending not zero");
    pend_top_zero_a: assert property (rd_ok && paddr == 8'h0c |-> prdata[31:6] == 26'h000_0000)
        else $error("pending upper bits not zero");
    tc_read_a: assert property (rd_ok && paddr == 8'h30 |-> prdata[7:0] == chan_ctrl[0].wr[12])
        else $error("time constant low read wrong");
    enables_write_a: assert property (acc && pwrite && paddr == 8'h3c
        |=> chan_ctrl[0].wr[15] == $past(pwdata[7:0]))
        else $error("enables write lost");
    feature_write_a: assert property (acc && pwrite && paddr == 8'h1c && chan_ctrl[0].wr[15][0]
        |=> chan_ctrl[0].feature == $past(pwdata[7:0]))
        else $error("feature write lost");
endmodule : serial_channel_status_regs_chk

bind serial_channel_status_regs serial_channel_status_regs_chk i_serial_channel_status_regs_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .chan_status(chan_status), .chan_ctrl(chan_ctrl));

// ==== dv/status_model.sv ====
// Datapath stand-in: registers the status the bench commands.
// Assumes the bench changes st_next only between bus transfers.
`timescale 1ns/1ps
module status_model (
    input wire logic pclk,
    input wire logic presetn,
    input serial_regs_pkg::chan_in_t [serial_regs_pkg::NUM_CHAN-1:0] st_next,
    output serial_regs_pkg::chan_in_t [serial_regs_pkg::NUM_CHAN-1:0] st
);
    import serial_regs_pkg::*;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= st_next;
        end
    end
endmodule : status_model

// ==== dv/tb_serial_channel_status_regs.sv ====
// Self-checking bench: APB register sequences with expected values.
// Assumes the status model adds one cycle before status reaches the bank.
`timescale 1ns/1ps
module tb_serial_channel_status_regs;
    import serial_regs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic pready, pslverr, irq;
    chan_in_t [NUM_CHAN-1:0] st_next = '0, chan_status;
    chan_ctrl_t [NUM_CHAN-1:0] chan_ctrl;
    int n_mismatch = 0, tests_run = 0;
    logic [7:0] ra[4] = '{8'h24, 8'h10, 8'h14, 8'h38};
    logic [7:0] xa[4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    serial_channel_status_regs i_serial_channel_status_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .chan_status(chan_status), .chan_ctrl(chan_ctrl));
    status_model i_status_model (.pclk(pclk), .presetn(presetn), .st_next(st_next), .st(chan_status));
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    ////////////////////////////////////////
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Read data and error are taken only at the edge that samples pready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h00_0000, d});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] x, input string name);
        xfer(1'b0, a, 32'h0000_0000);
        chk(name, r, {24'h00_0000, x});
    endtask : rd
    // Status lands after the model flop plus the pending lag
    task automatic prim(input int c, input logic [7:0] p);
        @(posedge pclk);
        st_next[c].primary <= p;
        repeat (3) @(posedge pclk);
    endtask : prim
    task automatic irq_is(input logic x);
        repeat (3) @(posedge pclk);
        chk("irq", irq, x);
    endtask : irq_is
    ////////////////////////////////////////
    initial begin
        {st_next[0].eof, st_next[0].crc_err, st_next[0].overrun, st_next[0].parity_err,
            st_next[0].residue, st_next[0].all_sent} = 8'b1010_1101;
        st_next[1].rx_data = 8'h6e;
        st_next[0].misc_status = 8'h3c;
        st_next[0].frame_count_low = 8'h5a;
        st_next[0].frame_count_high = 8'ha5;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h3c, 8'hf8, "enables reset");
        rd(8'h84, 8'h00, "mask reset");
        rd(8'h88, 8'h00, "unmapped");
        chk("slverr", e, 1'b1);
        rd(8'h02, 8'h00, "unaligned");
        chk("slverr", e, 1'b1);
        rd(8'h04, 8'ha7, "special status");
        rd(8'h60, 8'h6e, "rx buffer B");
        rd(8'h28, 8'h3c, "misc status");
        prim(0, 8'h02);
        rd(8'h00, 8'h02, "primary A");
        rd(8'h80, 8'h00, "zero count disabled");
        prim(1, 8'h01);
        rd(8'h40, 8'h01, "primary B");
        rd(8'h0c, 8'h04, "pending via A");
        rd(8'h4c, 8'h00, "pending via B");
        irq_is(1'b0);
        wr(8'h84, 8'h02);
        irq_is(1'b0);
        wr(8'h84, 8'h06);
        irq_is(1'b1);
        rd(8'h80, 8'h04, "irq status");
        irq_is(1'b0);
        rd(8'h80, 8'h00, "irq cleared");
        wr(8'h08, 8'hf0);
        rd(8'h08, 8'hf0, "vector A");
        rd(8'h48, 8'hf6, "vector B idle");
        prim(0, 8'h03);
        rd(8'h48, 8'hfc, "vector B A rx");
        rd(8'h80, 8'h20, "A rx pending");
        prim(1, 8'h21);
        rd(8'h48, 8'hf2, "vector B B ext");
        rd(8'h80, 8'h01, "B ext pending");
        wr(8'h3c, 8'hfa);
        prim(0, 8'h01);
        prim(0, 8'h03);
        rd(8'h80, 8'h08, "zero count enabled");
        rd(8'h18, 8'hf0, "frame low off");
        wr(8'h3c, 8'hfe);
        // Write lands at the completing edge; look one edge later
        @(posedge pclk);
        chk("enables", chan_ctrl[0].wr[15], 8'hfe);
        rd(8'h18, 8'h5a, "frame low");
        rd(8'h1c, 8'ha5, "frame high");
        wr(8'h0c, 8'h11);
        wr(8'h10, 8'h22);
        wr(8'h14, 8'h33);
        wr(8'h28, 8'h44);
        wr(8'h30, 8'h12);
        wr(8'h34, 8'h34);
        rd(8'h30, 8'h12, "tc low");
        rd(8'h34, 8'h34, "tc high");
        rd(8'h24, 8'h34, "idx9 plain");
        rd(8'h38, 8'h3c, "idx14 plain");
        wr(8'h3c, 8'hff);
        wr(8'h1c, 8'h40);
        @(posedge pclk);
        chk("feature", chan_ctrl[0].feature, 8'h40);
        foreach (ra[i]) rd(ra[i], xa[i], "readback");
        wrap_up();
    end
endmodule : tb_serial_channel_status_regs
